// File: logic/rfsr_consts.svh
// Register word indices, field positions and reset values of the driver segment and threshold bank
`ifndef RFSR_CONSTS_SVH
`define RFSR_CONSTS_SVH
`define RFSR_IDX_MOD_DEPTH 8'h25
`define RFSR_IDX_AM_SEG 8'h26
`define RFSR_IDX_NORM_SEG 8'h27
`define RFSR_IDX_THRESH 8'h29
`define RFSR_IDX_CTRL 8'h40
`define RFSR_IDX_STATUS 8'h41
`define RFSR_RST_MOD_DEPTH 8'h00
`define RFSR_RST_AM_SEG 8'h00
`define RFSR_RST_NORM_SEG 8'h00
`define RFSR_RST_THRESH 8'h33
`define RFSR_RST_CTRL 8'h00
`define RFSR_ALL_OFF 8'hFF
`define RFSR_CAL_FAIL 8'hFF
`define RFSR_THRESH_MASK 8'h7F
`define RFSR_PEER_HI 6
`define RFSR_PEER_LO 4
`define RFSR_COLL_HI 3
`define RFSR_COLL_LO 0
`define RFSR_CTRL_AM_SRC 0
`define RFSR_ADDR_IDX_HI 9
`define RFSR_ADDR_IDX_LO 2
`define RFSR_ADDR_BYTE_HI 1
`endif

// File: logic/rfsr_pkg.sv
// Types shared by the driver segment and threshold bank
package rfsr_pkg;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } rfsr_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } rfsr_apb_rsp_t;

    typedef struct packed {
        logic valid;
        logic fail;
        logic [7:0] segs;
    } rfsr_cal_t;

    typedef struct packed {
        logic [7:0] seg_off;
        logic tristate;
        logic [2:0] peer_detect_threshold;
        logic [3:0] collision_avoid_threshold;
    } rfsr_drv_t;

    typedef enum logic [1:0] {
        RFSR_IDLE,
        RFSR_ACCESS
    } rfsr_apb_state_t;
endpackage

// File: logic/rfsr_regs.sv
// APB register bank for driver segment disables, calibration result and field thresholds
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "rfsr_consts.svh"
module rfsr_regs
(
    input wire logic clock,
    input wire logic rst,
    input rfsr_pkg::rfsr_apb_req_t apb_req,
    output rfsr_pkg::rfsr_apb_rsp_t apb_rsp,
    input wire logic restore_defaults,
    input rfsr_pkg::rfsr_cal_t cal_done,
    input wire logic am_active,
    output rfsr_pkg::rfsr_drv_t drv
);
    import rfsr_pkg::*;

    logic [7:0] md_q;
    logic [7:0] md_d;
    logic [7:0] am_q;
    logic [7:0] am_d;
    logic [7:0] nm_q;
    logic [7:0] nm_d;
    logic [7:0] th_q;
    logic [7:0] th_d;
    logic src_q;
    logic src_d;
    logic cal_fail_q;
    logic cal_fail_d;
    rfsr_apb_state_t st_q;
    rfsr_apb_state_t st_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic err_q;
    logic err_d;
    logic [7:0] idx;
    logic hit;
    logic [7:0] rsel;
    logic [7:0] seg_off;
    logic tristate;
    logic wr_fire;

    assign idx = apb_req.paddr[`RFSR_ADDR_IDX_HI:`RFSR_ADDR_IDX_LO];

    // Address decode and read mux
    always_comb
    begin
        hit = 1'b1;
        rsel = 8'h00;
        case (idx)
            `RFSR_IDX_MOD_DEPTH: rsel = md_q;
            `RFSR_IDX_AM_SEG: rsel = am_q;
            `RFSR_IDX_NORM_SEG: rsel = nm_q;
            `RFSR_IDX_THRESH: rsel = th_q;
            `RFSR_IDX_CTRL: rsel = {7'h00, src_q};
            `RFSR_IDX_STATUS: rsel = {5'h00, tristate, am_active, cal_fail_q};
            default: hit = 1'b0;
        endcase
        if (apb_req.paddr[`RFSR_ADDR_BYTE_HI:0] != 2'h0 || apb_req.paddr[11:10] != 2'h0)
        begin
            hit = 1'b0;
        end
    end

    // APB slave: no wait state, answer in the first access cycle
    always_comb
    begin
        st_d = st_q;
        rdata_d = rdata_q;
        err_d = err_q;
        wr_fire = 1'b0;
        case (st_q)
            RFSR_IDLE:
            begin
                if (apb_req.psel && !apb_req.penable)
                begin
                    st_d = RFSR_ACCESS;
                    rdata_d = 32'h0000_0000;
                    err_d = 1'b0;
                end
            end
            RFSR_ACCESS:
            begin
                if (apb_req.psel && apb_req.penable)
                begin
                    st_d = RFSR_IDLE;
                    wr_fire = apb_req.pwrite && hit;
                end
                else
                begin
                    st_d = RFSR_IDLE;
                end
            end
            default: st_d = RFSR_IDLE;
        endcase
        if (st_q == RFSR_IDLE && apb_req.psel && !apb_req.penable)
        begin
            rdata_d = apb_req.pwrite ? 32'h0000_0000 : {24'h000000, rsel};
            err_d = !hit;
        end
    end

    // Register next values, restore and calibration take priority over software
    always_comb
    begin
        md_d = md_q;
        am_d = am_q;
        nm_d = nm_q;
        th_d = th_q;
        src_d = src_q;
        cal_fail_d = cal_fail_q;
        if (wr_fire)
        begin
            case (idx)
                `RFSR_IDX_AM_SEG: am_d = apb_req.pwdata[7:0];
                `RFSR_IDX_NORM_SEG: nm_d = apb_req.pwdata[7:0];
                `RFSR_IDX_THRESH: th_d = apb_req.pwdata[7:0] & `RFSR_THRESH_MASK;
                `RFSR_IDX_CTRL: src_d = apb_req.pwdata[`RFSR_CTRL_AM_SRC];
                default: md_d = md_q;
            endcase
        end
        if (cal_done.valid)
        begin
            md_d = cal_done.fail ? `RFSR_CAL_FAIL : cal_done.segs;
            cal_fail_d = cal_done.fail;
        end
        if (restore_defaults)
        begin
            md_d = `RFSR_RST_MOD_DEPTH;
            am_d = `RFSR_RST_AM_SEG;
            nm_d = `RFSR_RST_NORM_SEG;
            th_d = `RFSR_RST_THRESH;
            src_d = 1'b0;
            cal_fail_d = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            md_q <= `RFSR_RST_MOD_DEPTH;
            am_q <= `RFSR_RST_AM_SEG;
            nm_q <= `RFSR_RST_NORM_SEG;
            th_q <= `RFSR_RST_THRESH;
            src_q <= 1'b0;
            cal_fail_q <= 1'b0;
            st_q <= RFSR_IDLE;
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end
        else
        begin
            md_q <= md_d;
            am_q <= am_d;
            nm_q <= nm_d;
            th_q <= th_d;
            src_q <= src_d;
            cal_fail_q <= cal_fail_d;
            st_q <= st_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // Bus answer
    assign apb_rsp.pready = (st_q == RFSR_ACCESS);
    assign apb_rsp.prdata = rdata_q;
    assign apb_rsp.pslverr = (st_q == RFSR_ACCESS) && err_q;

    // Segment pattern selection
    rfsr_seg_mux u_seg_mux
    (
        .clock(clock),
        .rst(rst),
        .am_active(am_active),
        .am_level_source_select(src_q),
        .cal_depth_result(md_q),
        .am_segment_off(am_q),
        .normal_segment_off(nm_q),
        .seg_off(seg_off),
        .tristate(tristate)
    );

    // Driver controls and threshold codes
    assign drv.seg_off = seg_off;
    assign drv.tristate = tristate;
    assign drv.peer_detect_threshold = th_q[`RFSR_PEER_HI:`RFSR_PEER_LO];
    assign drv.collision_avoid_threshold = th_q[`RFSR_COLL_HI:`RFSR_COLL_LO];
endmodule // rfsr_regs

// File: logic/rfsr_seg_mux.sv
// Segment pattern selection for the antenna driver
`timescale 1ns/1ps
`include "rfsr_consts.svh"
module rfsr_seg_mux
(
    input wire logic clock,
    input wire logic rst,
    input wire logic am_active,
    input wire logic am_level_source_select,
    input wire logic [7:0] cal_depth_result,
    input wire logic [7:0] am_segment_off,
    input wire logic [7:0] normal_segment_off,
    output logic [7:0] seg_off,
    output logic tristate
);
    import rfsr_pkg::*;

    logic [7:0] seg_off_d;
    logic [7:0] seg_off_q;
    logic tri_d;
    logic tri_q;

    // Pick modulated or unmodulated pattern; bit 7 is the 2 ohm segment
    always_comb
    begin
        if (am_active)
        begin
            seg_off_d = am_level_source_select ? am_segment_off : cal_depth_result;
        end
        else
        begin
            seg_off_d = normal_segment_off;
        end
        tri_d = !am_active && (normal_segment_off == `RFSR_ALL_OFF);
    end

    // Registered driver controls
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            seg_off_q <= `RFSR_RST_NORM_SEG;
            tri_q <= 1'b0;
        end
        else
        begin
            seg_off_q <= seg_off_d;
            tri_q <= tri_d;
        end
    end

    assign seg_off = seg_off_q;
    assign tristate = tri_q;
endmodule // rfsr_seg_mux

// File: testbench/rfsr_props.sv
// Checker for the driver segment and threshold bank
`timescale 1ns/1ps
module rfsr_props
(
    input wire logic clock,
    input wire logic rst,
    input rfsr_pkg::rfsr_apb_req_t apb_req,
    input rfsr_pkg::rfsr_apb_rsp_t apb_rsp,
    input wire logic restore_defaults,
    input rfsr_pkg::rfsr_cal_t cal_done,
    input wire logic am_active,
    input rfsr_pkg::rfsr_drv_t drv
);
    import rfsr_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic wr;
    // Write taken at the access edge, not overridden by a restore
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && !restore_defaults;
    // Bus timing and read data shape
    ready_next_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("no pready in access cycle");
    ready_access_a: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
        else $error("pready outside access");
    upper_zero_a: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h000000)
        else $error("prdata upper bits set");
    // Driver outputs
    tri_unmod_a: assert property (drv.tristate |-> !$past(am_active))
        else $error("tristate while modulated");
    norm_seg_a: assert property (wr && apb_req.paddr == 12'h09C ##1 !am_active |=>
        drv.seg_off == $past(apb_req.pwdata[7:0], 2) && drv.tristate == ($past(apb_req.pwdata[7:0], 2) == 8'hFF))
        else $error("normal segment pattern wrong");
    // Threshold fields
    thr_restore_a: assert property (restore_defaults |=> drv.peer_detect_threshold == 3'h3 &&
        drv.collision_avoid_threshold == 4'h3) else $error("thresholds not restored");
    thr_hold_a: assert property (!wr && !restore_defaults |=> $stable(drv.collision_avoid_threshold))
        else $error("collision threshold changed");
    coll_write_a: assert property (wr && apb_req.paddr == 12'h0A4 |=>
        drv.collision_avoid_threshold == $past(apb_req.pwdata[3:0])) else $error("collision write lost");
    peer_write_a: assert property (wr && apb_req.paddr == 12'h0A4 |=>
        drv.peer_detect_threshold == $past(apb_req.pwdata[6:4])) else $error("peer write lost");
endmodule // rfsr_props
bind rfsr_regs rfsr_props u_props (.clock(clock), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .restore_defaults(restore_defaults), .cal_done(cal_done), .am_active(am_active), .drv(drv));

// File: testbench/tb.sv
// Self-checking bench for the driver segment and threshold bank
`timescale 1ns/1ps
`include "rfsr_consts.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("wrong value %s %0h %0h", n, e, g); end end
module tb;
    import rfsr_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic restore_defaults = 1'b0;
    logic am_active = 1'b0;
    rfsr_apb_req_t req = '0;
    rfsr_apb_rsp_t rsp;
    rfsr_cal_t cal = '0;
    rfsr_drv_t drv;
    int num_errors = 0;
    int checks = 0;
    logic [31:0] rd;
    logic err;
    // 40 MHz clock
    always #12.5 clock = ~clock;
    rfsr_regs DUT (.clock(clock), .rst(rst), .apb_req(req), .apb_rsp(rsp),
        .restore_defaults(restore_defaults), .cal_done(cal), .am_active(am_active), .drv(drv));
    // One APB transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clock);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {2'b00, idx, 2'b00}, pwdata: {24'h000000, d}};
        @(posedge clock);
        req.penable <= 1'b1;
        // Hold the access phase until pready; only the watchdog ends a hang
        do
        begin
            @(posedge clock);
        end
        while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        `CHK("prdata", {24'h000000, e}, rd)
        `CHK("pslverr", 1'b0, err)
    endtask
    // Driver outputs settle one cycle after the register
    task automatic segchk(input logic [7:0] s, input logic t);
        repeat (2) @(posedge clock);
        `CHK("seg_off", s, drv.seg_off)
        `CHK("tristate", t, drv.tristate)
    endtask
    task automatic pulse_cal(input logic f, input logic [7:0] s);
        @(posedge clock);
        cal <= '{valid: 1'b1, fail: f, segs: s};
        @(posedge clock);
        cal <= '0;
    endtask
    task automatic final_report;
        if (num_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #500000;
        num_errors++;
        final_report();
    end
    // Test sequence
    initial
    begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        rdchk(`RFSR_IDX_MOD_DEPTH, 8'h00);
        rdchk(`RFSR_IDX_AM_SEG, 8'h00);
        rdchk(`RFSR_IDX_NORM_SEG, 8'h00);
        rdchk(`RFSR_IDX_THRESH, 8'h33);
        for (int i = 0; i < 16; i++)
        begin
            apb(1'b1, `RFSR_IDX_THRESH, 8'(i * 17));
            @(posedge clock);
            `CHK("coll", 4'(i), drv.collision_avoid_threshold)
            `CHK("peer", 3'(i), drv.peer_detect_threshold)
        end
        rdchk(`RFSR_IDX_THRESH, 8'h7F);
        apb(1'b1, `RFSR_IDX_MOD_DEPTH, 8'hAA);
        rdchk(`RFSR_IDX_MOD_DEPTH, 8'h00);
        apb(1'b1, `RFSR_IDX_NORM_SEG, 8'hC0);
        segchk(8'hC0, 1'b0);
        apb(1'b1, `RFSR_IDX_NORM_SEG, 8'hFF);
        segchk(8'hFF, 1'b1);
        apb(1'b1, `RFSR_IDX_CTRL, 8'h01);
        rdchk(`RFSR_IDX_CTRL, 8'h01);
        apb(1'b1, `RFSR_IDX_AM_SEG, 8'h5A);
        am_active <= 1'b1;
        segchk(8'h5A, 1'b0);
        pulse_cal(1'b0, 8'h3C);
        rdchk(`RFSR_IDX_MOD_DEPTH, 8'h3C);
        apb(1'b1, `RFSR_IDX_CTRL, 8'h00);
        segchk(8'h3C, 1'b0);
        pulse_cal(1'b1, 8'h12);
        rdchk(`RFSR_IDX_MOD_DEPTH, 8'hFF);
        rdchk(`RFSR_IDX_STATUS, 8'h03);
        // Recommended active-mode collision setting, then restore from it
        apb(1'b1, `RFSR_IDX_THRESH, 8'h37);
        @(posedge clock);
        `CHK("coll", 4'h7, drv.collision_avoid_threshold)
        @(posedge clock);
        restore_defaults <= 1'b1;
        @(posedge clock);
        restore_defaults <= 1'b0;
        rdchk(`RFSR_IDX_MOD_DEPTH, 8'h00);
        rdchk(`RFSR_IDX_AM_SEG, 8'h00);
        rdchk(`RFSR_IDX_NORM_SEG, 8'h00);
        rdchk(`RFSR_IDX_THRESH, 8'h33);
        rdchk(`RFSR_IDX_STATUS, 8'h02);
        apb(1'b0, 8'h30, 8'h00);
        `CHK("unmapped", 1'b1, err)
        final_report();
    end
endmodule // tb
